//--- waveform_pkg.sv
// constants shared by the waveform extension and its dead-time generators
// assumes byte-wide register port and timer compare waveforms on clk
package waveform_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] ctrl_addr = 4'h0;
  localparam logic [3:0] fault_mask_addr = 4'h1;
  localparam logic [3:0] fault_ctrl_addr = 4'h2;
  localparam logic [3:0] status_addr = 4'h3;
  localparam logic [3:0] irq_mask_addr = 4'h4;
  localparam logic [3:0] low_gap_addr = 4'h5;
  localparam logic [3:0] high_gap_addr = 4'h6;

  // control register fields
  localparam int gap_en_lsb = 0;
  localparam int common_bit = 4;
  localparam int pattern_bit = 5;
  localparam int halt_bit = 6;
  localparam logic [7:0] ctrl_mask = 8'h7f;

  // fault control and status fields
  localparam int fault_en_bit = 0;
  localparam int cycle_mode_bit = 1;
  localparam int flag_bit = 0;
  localparam int active_bit = 1;

  // values after reset: everything off, pins pass through
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] gap_reset = 8'h00;

  // longest cycles from fault event to outputs off
  localparam int fault_latency = 2;

endpackage

//--- gap_generator.sv
// one dead-time generator: splits a waveform into low and high side
// assumes the waveform input is driven from logic on clk
`timescale 1ns/1ps
module gap_generator
  import waveform_pkg::*;
#(
  parameter int width = 8
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wave,
  input wire logic enable,
  input wire logic [width-1:0] low_gap_count,
  input wire logic [width-1:0] high_gap_count,
  output logic low_side,
  output logic high_side,
  output logic busy
);

  initial
  begin
    if (width < 1 || width > 8)
      $error("gap_generator width must be 1 to 8");
  end

  // whole state of the generator
  typedef struct packed {
    logic prev;
    logic [width-1:0] cnt;
    logic low;
    logic high;
  } gap_state_type;

  gap_state_type s_r;
  gap_state_type s_nxt;

  // next state: reload on edges, count down, gate outputs
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.prev = wave;
    if (!enable)
    begin
      // idle generator holds no gap
      s_nxt.cnt = '0;
    end
    else if (wave && !s_r.prev)
    begin
      s_nxt.cnt = low_gap_count;
    end
    else if (!wave && s_r.prev)
    begin
      s_nxt.cnt = high_gap_count;
    end
    else if (s_r.cnt != '0)
    begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    // low side follows, high side inverts, both off in a gap
    s_nxt.low = enable && wave && (s_nxt.cnt == '0);
    s_nxt.high = enable && !wave && (s_nxt.cnt == '0);
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign low_side = s_r.low;
  assign high_side = s_r.high;
  assign busy = s_r.cnt != '0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence rise_s;
    enable && wave && !s_r.prev;
  endsequence

  sides_exclusive_a: assert property (!(low_side && high_side))
    else $error("low and high side both on");
  gap_forces_off_a: assert property (busy |-> !low_side && !high_side)
    else $error("output on during dead time");
  rise_reload_a: assert property (rise_s |=> s_r.cnt == $past(low_gap_count))
    else $error("rising edge did not reload low gap");
  count_down_a: assert property
    (enable && busy && wave == s_r.prev |=> s_r.cnt == $past(s_r.cnt) - 1'b1)
    else $error("dead-time counter did not decrement");

endmodule

//--- waveform_extension.sv
// waveform extension: dead time, pattern output and fault shutdown
// assumes timer waveforms, update pulse and events come from logic on clk
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module waveform_extension
  import waveform_pkg::*;
#(
  parameter int channels = 4,
  parameter int gap_width = 8,
  parameter int event_count = 8
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [channels-1:0] waveform_out,
  input wire logic update,
  input wire logic [2*channels-1:0] port_value,
  input wire logic [2*channels-1:0] port_dir,
  input wire logic [event_count-1:0] fault_event,
  output logic [2*channels-1:0] pin_out,
  output logic [2*channels-1:0] pin_oe,
  output logic timer_halt,
  output logic irq
);

  localparam int pins = 2 * channels;

  // register fields are a byte wide, so exactly four pairs
  initial
  begin
    if (channels != 4 || gap_width != 8 || event_count < 1 || event_count > 8)
      $error("waveform_extension needs four channels, 8-bit gaps, 1..8 events");
  end

  // whole state of the extension
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] fmask;
    logic [1:0] fctrl;
    logic flag;
    logic active;
    logic irq_mask;
    logic [7:0] low_buf;
    logic [7:0] high_buf;
    logic [7:0] low_gap;
    logic [7:0] high_gap;
    logic [7:0] rdata;
    logic [pins-1:0] pin;
    logic [pins-1:0] oe;
    logic halt;
    logic irq;
  } ext_state_type;

  ext_state_type s_r;
  ext_state_type s_nxt;

  // decoded control bits and internal signals
  logic [channels-1:0] gap_en; // per-channel dead-time enable
  logic pattern_mode; // pattern generator on
  logic common_mode; // channel A feeds every generator
  logic fault_hit; // a selected event this cycle
  logic [7:0] event_bits; // events padded to a byte
  logic [channels-1:0] gen_wave; // waveform into each generator
  logic [channels-1:0] gen_en; // generator actually running
  logic [channels-1:0] low_side; // generator low side outputs
  logic [channels-1:0] high_side; // generator high side outputs
  logic [channels-1:0] busy; // generator inside dead time
  logic status_clear; // software writes one to the flag

  assign gap_en = s_r.ctrl[gap_en_lsb +: channels];
  assign pattern_mode = s_r.ctrl[pattern_bit];
  // pattern mode implies common channel mode
  assign common_mode = s_r.ctrl[common_bit] || pattern_mode;
  assign event_bits = 8'(fault_event);
  // events act as levels: one held high keeps re-entering the fault
  assign fault_hit = s_r.fctrl[fault_en_bit] && |(event_bits & s_r.fmask);
  // only the flag bit clears; the active bit cannot be written
  assign status_clear = reg_wr && reg_addr == status_addr && reg_wdata[flag_bit];

  // generators see channel A alone in common mode
  always_comb
  begin
    for (int i = 0; i < channels; i++)
    begin
      gen_wave[i] = common_mode ? waveform_out[0] : waveform_out[i];
      gen_en[i] = gap_en[i] && !pattern_mode;
    end
  end

  // four identical dead-time generators, one per compare channel
  generate
    for (genvar g = 0; g < channels; g++)
    begin : gen_gap
      // each generator registers its sides, so pins trail an edge by two
      gap_generator #(
        .width(gap_width)
      ) gap_generator_inst (
        .clk(clk),
        .reset(reset),
        .wave(gen_wave[g]),
        .enable(gen_en[g]),
        .low_gap_count(s_r.low_gap),
        .high_gap_count(s_r.high_gap),
        .low_side(low_side[g]),
        .high_side(high_side[g]),
        .busy(busy[g])
      );
    end
  endgenerate

  // next state: register port, buffers, fault state, pin mux
  always_comb
  begin
    s_nxt = s_r;
    // read data stands for one cycle only
    s_nxt.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        ctrl_addr: s_nxt.rdata = s_r.ctrl;
        fault_mask_addr: s_nxt.rdata = s_r.fmask;
        fault_ctrl_addr: s_nxt.rdata = {6'h00, s_r.fctrl};
        status_addr: s_nxt.rdata = {6'h00, s_r.active, s_r.flag};
        irq_mask_addr: s_nxt.rdata = {7'h00, s_r.irq_mask};
        low_gap_addr: s_nxt.rdata = s_r.low_buf;
        high_gap_addr: s_nxt.rdata = s_r.high_buf;
        default: s_nxt.rdata = 8'h00; // unmapped reads zero
      endcase
    end
    // dead-time writes land in the buffers, not in the active values
    if (reg_wr)
    begin
      case (reg_addr)
        ctrl_addr: s_nxt.ctrl = reg_wdata & ctrl_mask;
        fault_mask_addr: s_nxt.fmask = reg_wdata;
        fault_ctrl_addr: s_nxt.fctrl = reg_wdata[1:0];
        irq_mask_addr: s_nxt.irq_mask = reg_wdata[0];
        low_gap_addr: s_nxt.low_buf = reg_wdata;
        high_gap_addr: s_nxt.high_buf = reg_wdata;
        default: s_nxt.fmask = s_r.fmask; // status and unmapped: no store
      endcase
    end
    // buffered values go live only at the timer update point
    if (update)
    begin
      s_nxt.low_gap = s_r.low_buf;
      s_nxt.high_gap = s_r.high_buf;
    end
    // sticky flag: a new fault beats a simultaneous clear
    s_nxt.flag = (s_r.flag && !status_clear) || fault_hit;
    // fault state: enter at once, leave only at an update
    if (fault_hit)
    begin
      s_nxt.active = 1'b1;
    end
    else if (s_r.active && update)
    begin
      // latched mode also waits for software to clear the flag
      if (s_r.fctrl[cycle_mode_bit] || !s_r.flag)
        s_nxt.active = 1'b0;
    end
    // pins pass through unless a feature claims them
    s_nxt.pin = port_value;
    s_nxt.oe = port_dir;
    for (int i = 0; i < channels; i++)
    begin
      if (pattern_mode)
      begin
        // live low dead-time value holds override enables, live high value the pattern
        s_nxt.pin[2*i] = s_r.low_gap[2*i] ? waveform_out[0] : s_r.high_gap[2*i];
        s_nxt.pin[2*i+1] = s_r.low_gap[2*i+1] ? waveform_out[0]
                                                  : s_r.high_gap[2*i+1];
      end
      else if (gap_en[i])
      begin
        s_nxt.pin[2*i] = low_side[i];
        s_nxt.pin[2*i+1] = high_side[i];
      end
    end
    // trade: a longer path from events to pins buys a cycle of latency
    // fault clears drive on every pin; uses next state for speed
    if (s_nxt.active)
    begin
      s_nxt.pin = '0;
      s_nxt.oe = '0;
    end
    // halt timer while any running generator is in dead time
    s_nxt.halt = s_r.ctrl[halt_bit] && |(busy & gen_en);
    s_nxt.irq = s_nxt.flag && s_r.irq_mask;
  end

  // state register, all features off after reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r <= '0;
      // named fields restated so their reset values stay visible
      s_r.ctrl <= ctrl_reset;
      s_r.low_gap <= gap_reset;
      s_r.high_gap <= gap_reset;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs come straight from the state register
  assign reg_rdata = s_r.rdata;
  assign pin_out = s_r.pin;
  assign pin_oe = s_r.oe;
  assign timer_halt = s_r.halt;
  assign irq = s_r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // fault entry then the pins drop
  sequence fault_seen_s;
    fault_hit;
  endsequence
  sequence pins_off_s;
    pin_oe == '0 && pin_out == '0;
  endsequence
  // exit steps: update with no event, then the port takes the pins back
  sequence cycle_exit_s;
    s_r.active && update && !fault_hit && s_r.fctrl[cycle_mode_bit];
  endsequence
  sequence latched_exit_s;
    s_r.active && update && !fault_hit && !s_r.fctrl[cycle_mode_bit] && !s_r.flag;
  endsequence
  sequence pins_back_s;
    !s_r.active && pin_oe == $past(port_dir);
  endsequence

  fault_shutdown_a: assert property (fault_seen_s |-> ##[1:2] pins_off_s)
    else $error("fault did not shut outputs in time");
  flag_set_wins_a: assert property (fault_hit && status_clear |=> s_r.flag)
    else $error("fault flag lost against clear");
  gap_only_update_a: assert property
    (!update |=> $stable(s_r.low_gap) && $stable(s_r.high_gap))
    else $error("dead time changed without update");
  gap_load_update_a: assert property (update |=> s_r.high_gap == $past(s_r.high_buf))
    else $error("dead time not loaded at update");
  pass_through_a: assert property
    (s_r.ctrl == 8'h00 && !s_nxt.active |=> pin_out == $past(port_value))
    else $error("disabled extension altered port values");
  pattern_bypass_a: assert property
    (pattern_mode && !s_nxt.active && s_r.low_gap == 8'h00
     |=> pin_out == $past(s_r.high_gap[pins-1:0]))
    else $error("pattern mode not bypassing dead time");
  channel_a_route_a: assert property
    (pattern_mode && !s_nxt.active && s_r.low_gap[0]
     |=> pin_out[0] == $past(waveform_out[0]))
    else $error("override pin missed channel A waveform");
  split_pair_a: assert property
    (!pattern_mode && gap_en[1] && !s_nxt.active |=> pin_out[3:2] == $past({high_side[1],
                                                                          low_side[1]}))
    else $error("pin pair not driven by generator");
  halt_gap_a: assert property
    (s_r.ctrl[halt_bit] && |(busy & gen_en) |=> timer_halt)
    else $error("timer not halted during dead time");
  rdata_one_cycle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data held past one cycle");

  // register port: a write lands one cycle on, a read answers one cycle on
  ctrl_write_a: assert property
    (reg_wr && reg_addr == ctrl_addr |=> s_r.ctrl == ($past(reg_wdata) & ctrl_mask))
    else $error("control write did not land");
  ctrl_read_a: assert property
    (reg_rd && reg_addr == ctrl_addr |=> reg_rdata == $past(s_r.ctrl))
    else $error("control read returned wrong data");
  status_read_a: assert property
    (reg_rd && reg_addr == status_addr
     |=> reg_rdata == {6'h00, $past(s_r.active), $past(s_r.flag)})
    else $error("status read returned wrong data");
  // both halves of the double buffer move at the same update
  low_load_update_a: assert property (update |=> s_r.low_gap == $past(s_r.low_buf))
    else $error("low dead time not loaded at update");
  // a running generator inside its gap keeps both pins of its leg off
  dead_gap_off_a: assert property
    (!pattern_mode && gap_en[0] && busy[0] && !s_nxt.active |=> pin_out[1:0] == 2'b00)
    else $error("leg driven during dead time");
  // halt only ever comes from the enable bit
  halt_needs_bit_a: assert property (timer_halt |-> $past(s_r.ctrl[halt_bit]))
    else $error("timer halted with halt disabled");
  // outside a fault the directions are never touched
  oe_follows_dir_a: assert property (!s_nxt.active |=> pin_oe == $past(port_dir))
    else $error("pin direction altered outside fault");
  // fault state: events set it, only an update with no event clears it
  event_sets_flag_a: assert property (fault_hit |=> s_r.flag && s_r.active)
    else $error("event did not set fault flag and state");
  sticky_flag_a: assert property (s_r.flag && !status_clear |=> s_r.flag)
    else $error("fault flag dropped without clear");
  flag_clear_a: assert property (status_clear && !fault_hit |=> !s_r.flag)
    else $error("fault flag not cleared by write");
  irq_from_flag_a: assert property (irq |-> s_r.flag)
    else $error("interrupt without fault flag");
  fault_pins_off_a: assert property (s_r.active |-> pin_oe == '0 && pin_out == '0)
    else $error("pins driven in fault state");
  fault_holds_a: assert property (s_r.active && !update |=> s_r.active)
    else $error("fault state left without update");
  latched_hold_a: assert property
    (s_r.active && !s_r.fctrl[cycle_mode_bit] && s_r.flag |=> s_r.active)
    else $error("latched fault left with flag set");
  // exit takes one update; pins and directions come back in the same step
  cycle_exit_a: assert property (cycle_exit_s |=> pins_back_s)
    else $error("cycle mode fault did not end at update");
  latched_exit_a: assert property (latched_exit_s |=> pins_back_s)
    else $error("latched fault did not end at update");

endmodule

//--- power_stage.sv
// model of the external half-bridge drivers hanging on the pin pairs
// assumes pin 2i is the low switch and pin 2i+1 the high switch of leg i
`timescale 1ns/1ps
module power_stage
(
  input wire logic clk,
  input wire logic armed,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  output int shoot_count
);
  // a leg with both switches driven on shorts the supply
  initial shoot_count = 0;
  always @(posedge clk)
  begin
    // pattern mode may light both pins on purpose, so the bench arms it
    for (int i = 0; i < 4; i++)
    begin
      if (armed && pin_oe[2*i] && pin_oe[2*i+1] && pin_out[2*i] && pin_out[2*i+1])
        shoot_count <= shoot_count + 1;
    end
  end
endmodule

//--- tb_top.sv
// bench for the waveform extension: registers, dead time, pattern, fault
// assumes the design registers pins one cycle after its inputs
`timescale 1ns/1ps
module tb_top;
  import waveform_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [7:0] reg_rdata;
  logic [3:0] waveform_out = 4'h0;
  logic update = 0;
  logic [7:0] port_value = 8'h5a;
  logic [7:0] port_dir = 8'hff;
  logic [7:0] fault_event = 8'h00;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic timer_halt;
  logic irq;
  logic armed = 0;
  int shoot_count;
  int fails = 0;
  int tests_run = 0;
  int n;
  // 250 MHz clock
  always #2 clk = ~clk;
  waveform_extension waveform_extension_inst (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .waveform_out(waveform_out), .update(update),
    .port_value(port_value), .port_dir(port_dir), .fault_event(fault_event),
    .pin_out(pin_out), .pin_oe(pin_oe), .timer_halt(timer_halt), .irq(irq));
  power_stage power_stage_inst (.clk(clk), .armed(armed), .pin_out(pin_out),
    .pin_oe(pin_oe), .shoot_count(shoot_count));
  // one comparison, counted
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one-cycle write strobe
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1;
    chk(what, exp, reg_rdata);
  endtask
  task pulse_update();
    @(posedge clk);
    update <= 1;
    @(posedge clk);
    update <= 0;
  endtask
  // edge on channel A, count edges until the given pin turns on
  task gap_time(input logic v, input int idx, input int exp);
    @(posedge clk);
    waveform_out[0] <= v;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (pin_out[idx] !== 1'b1 && n < 40);
    chk("gap cycles", exp[7:0], n[7:0]);
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 0;
    repeat (2) @(posedge clk);
    #1;
    chk("pins after reset", port_value, pin_out);
    chk("oe after reset", port_dir, pin_oe);
    rd(ctrl_addr, ctrl_reset, "ctrl reset");
    wr(4'h7, 8'hff);
    rd(4'h7, 8'h00, "unmapped");
    wr(ctrl_addr, 8'hff);
    rd(ctrl_addr, ctrl_mask, "ctrl bits");
    $display("registers done");
    // dead time: distinct low and high values, loaded at update
    wr(ctrl_addr, 8'h00);
    wr(low_gap_addr, 8'h03);
    wr(high_gap_addr, 8'h02);
    pulse_update();
    wr(ctrl_addr, 8'h13);
    armed <= 1;
    gap_time(1, 0, 5);
    chk("common leg", 8'h01, {6'h0, pin_out[3:2]});
    gap_time(0, 1, 4);
    wr(low_gap_addr, 8'h06);
    gap_time(1, 0, 5);
    gap_time(0, 1, 4);
    pulse_update();
    gap_time(1, 0, 8);
    chk("shoot through", 8'h00, shoot_count[7:0]);
    // halt timer while counting
    wr(ctrl_addr, 8'h41);
    @(posedge clk);
    waveform_out[0] <= 0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (timer_halt !== 1'b1 && n < 4);
    chk("halt", 8'h01, {7'h0, timer_halt});
    armed <= 0;
    $display("dead time done");
    // pattern: override pins 0..3 carry channel A, rest the pattern
    wr(ctrl_addr, 8'h20);
    wr(low_gap_addr, 8'h0f);
    wr(high_gap_addr, 8'ha0);
    pulse_update();
    waveform_out[0] <= 1;
    repeat (3) @(posedge clk);
    #1;
    chk("pattern high", 8'haf, pin_out);
    waveform_out[0] <= 0;
    repeat (3) @(posedge clk);
    #1;
    chk("pattern low", 8'ha0, pin_out);
    $display("pattern done");
    // fault: latched mode, mask, raise, clear
    wr(ctrl_addr, 8'h00);
    wr(fault_mask_addr, 8'h02);
    wr(fault_ctrl_addr, 8'h01);
    wr(irq_mask_addr, 8'h01);
    @(posedge clk);
    fault_event <= 8'h01;
    repeat (3) @(posedge clk);
    #1;
    chk("masked event", port_dir, pin_oe);
    @(posedge clk);
    fault_event <= 8'h02;
    repeat (2) @(posedge clk);
    #1;
    chk("fault oe", 8'h00, pin_oe);
    chk("fault out", 8'h00, pin_out);
    chk("irq on", 8'h01, {7'h0, irq});
    fault_event <= 8'h00;
    rd(status_addr, 8'h03, "status");
    pulse_update();
    repeat (2) @(posedge clk);
    #1;
    chk("latched", 8'h00, pin_oe);
    wr(status_addr, 8'h01);
    pulse_update();
    repeat (2) @(posedge clk);
    #1;
    chk("restored", port_dir, pin_oe);
    chk("irq off", 8'h00, {7'h0, irq});
    // cycle mode: event held across a clear, exit at update with flag set
    wr(fault_ctrl_addr, 8'h03);
    fault_event <= 8'h02;
    wr(status_addr, 8'h01);
    fault_event <= 8'h00;
    #1;
    chk("cycle fault oe", 8'h00, pin_oe);
    rd(status_addr, 8'h03, "set beats clear");
    pulse_update();
    @(posedge clk);
    #1;
    chk("cycle restored", port_dir, pin_oe);
    rd(status_addr, 8'h01, "cycle status");
    wr(status_addr, 8'h01);
    $display("fault done");
    tally_and_finish();
  end
  // cut a hang short
  initial
  begin
    #200000;
    fails++;
    tally_and_finish();
  end
endmodule
